// ==== core/qa_pkg.sv ====
// Constants and types for the queue accounting and random discard block.
// Assumes a single 20 MHz clock and a word-indexed register port.
`default_nettype none
package qa_pkg;
    // Register word addresses
    localparam logic [7:0] QA_ADDR_ADJ    = 8'h00;
    localparam logic [7:0] QA_ADDR_OVR    = 8'h01;
    localparam logic [7:0] QA_ADDR_MBS    = 8'h02;
    localparam logic [7:0] QA_ADDR_ASSIGN = 8'h03;
    localparam logic [7:0] QA_ADDR_LOCAL  = 8'h04;
    localparam logic [7:0] QA_ADDR_EXIST  = 8'h05;
    localparam logic [7:0] QA_ADDR_DEPTH  = 8'h06;
    localparam logic [7:0] QA_ADDR_SLOPE  = 8'h08;
    localparam logic [7:0] QA_ADDR_CNT    = 8'h10;
    // Field positions
    localparam int QA_DIR_BIT  = 6;
    localparam int QA_EN_BIT   = 7;
    localparam int QA_SL_MAXU  = 8;
    localparam int QA_SL_MAXP  = 16;
    localparam int QA_SL_EN    = 24;
    // Sizes and limits
    localparam int QA_NPROF    = 4;
    localparam int QA_NSLOPE   = 8;
    localparam int QA_NCNT     = 6;
    localparam logic [5:0] QA_ADD_MAX = 6'h14;
    localparam logic [5:0] QA_SUB_MAX = 6'h2B;
    localparam logic [3:0] QA_PREAMBLE = 4'h8;
    localparam logic [6:0] QA_PCT_FULL = 7'h64;
    localparam logic [7:0] QA_RND_SPAN = 8'h80;
    // Reset values
    localparam logic [19:0] QA_MBS_RST   = 20'h10000;
    localparam logic [15:0] QA_LFSR_SEED = 16'hACE1;
    localparam logic [6:0]  QA_HI_START  = 7'h64;
    localparam logic [6:0]  QA_HI_MAXU   = 7'h64;
    localparam logic [6:0]  QA_HI_MAXP   = 7'h64;
    localparam logic [6:0]  QA_LO_START  = 7'h5A;
    localparam logic [6:0]  QA_LO_MAXU   = 7'h5A;
    localparam logic [6:0]  QA_LO_MAXP   = 7'h01;
    // Packet profile codes
    localparam logic [1:0] QA_PROF_UNDEF = 2'h0;
    localparam logic [1:0] QA_PROF_IN    = 2'h1;
    localparam logic [1:0] QA_PROF_OUT   = 2'h2;

    typedef struct packed {
        logic [6:0] start;
        logic [6:0] maxu;
        logic [6:0] maxp;
        logic       en;
    } qa_slope_t;
endpackage
`default_nettype wire

// ==== core/qa_queue_acct.sv ====
// One queue: accounting size adjustment, counters and slope based discard.
// Assumes packets arrive one per cycle at most, lengths exclude preamble.
//
// What this block does
// [RULE1] Default size is header, payload and CRC
// [RULE2] Adjusted size feeds counters and rate buckets
// [RULE3] Shaper and port use full wire size
// [RULE4] Add at most 20, subtract at most 43
// [RULE5] Software picks one direction with amount
// [RULE6] Adjustment touches accounting length only
// [RULE7] Override replaces the queue adjustment
// [RULE8] Cleared adjustment is zero, override kept
// [RULE9] Ingress slope from profile, else priority
// [RULE10] Egress slope from ingress profile
// [RULE11] Discard all once depth reaches MBS
// [RULE12] Zero probability below start utilization
// [RULE13] Max probability at knee, then 100%
// [RULE14] Random discard rising with depth
// [RULE15] Profile edits take effect at once
// [RULE16] Default profile used when none assigned
// [RULE17] Factory default high and low slopes
// [RULE18] Unknown profile leaves assignment unchanged
// [RULE19] Revert to default spares local override
// [RULE20] Linear interpolation against random value
//
// Added by the designer: the address map and the strobed register port.
`default_nettype none
module qa_queue_acct
    import qa_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic        pkt_valid_i,
    input  wire logic [13:0] pkt_len_i,
    input  wire logic        pkt_prio_hi_i,
    input  wire logic [1:0]  pkt_prof_i,
    input  wire logic        pkt_egress_i,
    input  wire logic        deq_valid_i,
    input  wire logic [13:0] deq_len_i,
    output logic             res_valid_o,
    output logic             res_drop_o,
    output logic             res_hi_slope_o,
    output logic      [13:0] res_acct_len_o,
    output logic      [14:0] res_wire_len_o,
    output logic      [13:0] res_tx_len_o
);
    import qa_pkg::*;

    typedef struct packed {
        logic [5:0]                  adj_amt;
        logic                        adj_sub;
        logic [5:0]                  ovr_amt;
        logic                        ovr_sub;
        logic                        ovr_en;
        logic [19:0]                 mbs;
        logic [1:0]                  prof_id;
        logic [1:0]                  loc_id;
        logic                        loc_en;
        logic [QA_NPROF-1:0]         exist;
        logic [19:0]                 depth;
        logic [15:0]                 lfsr;
        qa_slope_t [QA_NSLOPE-1:0]   slope;
        logic [QA_NCNT-1:0][31:0]    cnt;
        logic [31:0]                 rdata;
        logic                        res_valid;
        logic                        res_drop;
        logic                        res_hi;
        logic [13:0]                 res_acct;
        logic [14:0]                 res_wire;
        logic [13:0]                 res_tx;
    } qa_state_t;

    qa_state_t st;
    qa_state_t next_st;
    logic      rst_meta;
    logic      rst_sync_n;

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Clamped adjusted length, never below zero
    function automatic logic [13:0] adj_len(input logic [13:0] len,
                                            input logic [5:0] amt,
                                            input logic sub);
        logic [5:0] a;
        a = amt;
        if (sub) begin
            if (a > QA_SUB_MAX) a = QA_SUB_MAX;        // RULE4
            adj_len = (len > 14'(a)) ? len - 14'(a) : 14'h0000;
        end else begin
            if (a > QA_ADD_MAX) a = QA_ADD_MAX;        // RULE4
            adj_len = len + 14'(a);
        end
    endfunction

    // Discard decision for one slope at the present depth
    function automatic logic red_drop(input qa_slope_t sl,
                                      input logic [26:0] x,
                                      input logic [19:0] mbs,
                                      input logic [6:0] r);
        logic [26:0] s0;
        logic [26:0] k0;
        logic [47:0] lhs;
        logic [47:0] rhs;
        s0 = 27'(sl.start) * 27'(mbs);
        k0 = 27'(sl.maxu) * 27'(mbs);
        lhs = 48'(r) * 48'(k0 - s0) * 48'(QA_PCT_FULL);
        rhs = 48'(QA_RND_SPAN) * 48'(sl.maxp) * 48'(x - s0);
        if (!sl.en) red_drop = 1'b0;
        else if (x < s0) red_drop = 1'b0;              // RULE12
        else if (x >= k0) red_drop = 1'b1;             // RULE13
        else red_drop = (lhs < rhs);                   // RULE14 RULE20
    endfunction

    // Combinational helpers shared by logic and checks
    logic [1:0]  act_prof;
    qa_slope_t   sl_hi;
    qa_slope_t   sl_lo;
    qa_slope_t   sl_cur;
    logic        pick_hi;
    logic [26:0] util_x;
    logic        full;
    logic        drop_now;
    logic [13:0] acct_now;
    logic [5:0]  amt_eff;
    logic        sub_eff;

    always_comb begin
        act_prof = st.loc_en ? st.loc_id : st.prof_id;      // RULE19
        sl_hi    = st.slope[{act_prof, 1'b1}];              // RULE15 RULE16
        sl_lo    = st.slope[{act_prof, 1'b0}];
        if (pkt_prof_i == QA_PROF_IN) pick_hi = 1'b1;       // RULE9 RULE10
        else if (pkt_prof_i == QA_PROF_OUT) pick_hi = 1'b0; // RULE9 RULE10
        else pick_hi = pkt_prio_hi_i;                       // RULE9
        sl_cur   = pick_hi ? sl_hi : sl_lo;
        util_x   = 27'(st.depth) * 27'(QA_PCT_FULL);
        full     = (st.depth >= st.mbs);                    // RULE11
        drop_now = full | red_drop(pick_hi ? sl_hi : sl_lo, util_x,
                                   st.mbs, st.lfsr[6:0]);
        amt_eff  = st.ovr_en ? st.ovr_amt : st.adj_amt;     // RULE7
        sub_eff  = st.ovr_en ? st.ovr_sub : st.adj_sub;
        acct_now = adj_len(pkt_len_i, amt_eff, sub_eff);    // RULE2
    end

    // Next state: registers, counters, depth and results
    always_comb begin
        logic [20:0] dsum;
        logic [2:0]  base;
        int          si;
        next_st = st;
        dsum = 21'(st.depth);
        base = 3'h0;
        si = 0;
        next_st.lfsr = {st.lfsr[14:0],
                        st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
        next_st.res_valid = pkt_valid_i;
        if (pkt_valid_i) begin
            next_st.res_drop = drop_now;
            next_st.res_hi   = pick_hi;
            next_st.res_acct = acct_now;                     // RULE6
            next_st.res_wire = 15'(pkt_len_i) + 15'(QA_PREAMBLE); // RULE1 RULE3
            next_st.res_tx   = pkt_len_i;                    // RULE6
            base = pick_hi ? 3'h0 : 3'h1;
            next_st.cnt[base] = st.cnt[base] + 32'(acct_now);
            if (drop_now) begin
                next_st.cnt[base + 3'h2] = st.cnt[base + 3'h2] + 32'(acct_now);
            end else begin
                next_st.cnt[base + 3'h4] = st.cnt[base + 3'h4] + 32'(acct_now);
                dsum = dsum + 21'(pkt_len_i);
            end
        end
        if (deq_valid_i) begin
            dsum = (dsum > 21'(deq_len_i)) ? dsum - 21'(deq_len_i) : 21'h000000;
        end
        next_st.depth = dsum[20] ? 20'hFFFFF : dsum[19:0];
        // Register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                QA_ADDR_ADJ: begin
                    next_st.adj_amt = reg_wdata_i[5:0];       // RULE5 RULE8
                    next_st.adj_sub = reg_wdata_i[QA_DIR_BIT];
                end
                QA_ADDR_OVR: begin
                    next_st.ovr_amt = reg_wdata_i[5:0];
                    next_st.ovr_sub = reg_wdata_i[QA_DIR_BIT];
                    next_st.ovr_en  = reg_wdata_i[QA_EN_BIT];
                end
                QA_ADDR_MBS: next_st.mbs = reg_wdata_i[19:0];
                QA_ADDR_ASSIGN: begin
                    if (st.exist[reg_wdata_i[1:0]]) begin     // RULE18
                        next_st.prof_id = reg_wdata_i[1:0];
                    end
                end
                QA_ADDR_LOCAL: begin
                    next_st.loc_id = reg_wdata_i[1:0];
                    next_st.loc_en = reg_wdata_i[2];
                end
                QA_ADDR_EXIST: next_st.exist = reg_wdata_i[QA_NPROF-1:0] | 4'h1;
                default: begin
                    if (reg_addr_i[7:3] == QA_ADDR_SLOPE[7:3]) begin
                        si = int'(reg_addr_i[2:0]);
                        next_st.slope[si].start = reg_wdata_i[6:0];   // RULE15
                        next_st.slope[si].maxu  = reg_wdata_i[QA_SL_MAXU +: 7];
                        next_st.slope[si].maxp  = reg_wdata_i[QA_SL_MAXP +: 7];
                        next_st.slope[si].en    = reg_wdata_i[QA_SL_EN];
                    end
                end
            endcase
        end
        // Register reads, data in the following cycle
        next_st.rdata = 32'h00000000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                QA_ADDR_ADJ:    next_st.rdata = {25'h0, st.adj_sub, st.adj_amt};
                QA_ADDR_OVR:    next_st.rdata = {24'h0, st.ovr_en, st.ovr_sub, st.ovr_amt};
                QA_ADDR_MBS:    next_st.rdata = {12'h000, st.mbs};
                QA_ADDR_ASSIGN: next_st.rdata = {30'h0, st.prof_id};
                QA_ADDR_LOCAL:  next_st.rdata = {29'h0, st.loc_en, st.loc_id};
                QA_ADDR_EXIST:  next_st.rdata = {28'h0, st.exist};
                QA_ADDR_DEPTH:  next_st.rdata = {12'h000, st.depth};
                default: begin
                    if (reg_addr_i[7:3] == QA_ADDR_SLOPE[7:3]) begin
                        si = int'(reg_addr_i[2:0]);
                        next_st.rdata = {7'h00, st.slope[si].en, 1'b0, st.slope[si].maxp,
                                         1'b0, st.slope[si].maxu, 1'b0, st.slope[si].start};
                    end else if (reg_addr_i >= QA_ADDR_CNT &&
                                 reg_addr_i < QA_ADDR_CNT + 8'(QA_NCNT)) begin
                        next_st.rdata = st.cnt[3'(reg_addr_i - QA_ADDR_CNT)];
                    end
                end
            endcase
        end
    end

    // State register; every profile starts at factory values
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st         <= '0;
            st.mbs     <= QA_MBS_RST;
            st.exist   <= 4'h1;                             // RULE16
            st.lfsr    <= QA_LFSR_SEED;
            for (int p = 0; p < QA_NPROF; p++) begin
                st.slope[2*p+1] <= '{QA_HI_START, QA_HI_MAXU, QA_HI_MAXP, 1'b0}; // RULE17
                st.slope[2*p]   <= '{QA_LO_START, QA_LO_MAXU, QA_LO_MAXP, 1'b1}; // RULE17
            end
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o    = st.rdata;
    assign res_valid_o    = st.res_valid;
    assign res_drop_o     = st.res_drop;
    assign res_hi_slope_o = st.res_hi;
    assign res_acct_len_o = st.res_acct;
    assign res_wire_len_o = st.res_wire;
    assign res_tx_len_o   = st.res_tx;

    // Checks on the result stream
    property p_wire;
        @(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i |=> res_wire_len_o == 15'($past(pkt_len_i)) + 15'(QA_PREAMBLE);
    endproperty
    a_wire: assert property (p_wire) else $error("wire length wrong"); // RULE3

    property p_full;
        @(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && st.depth >= st.mbs |=> res_valid_o && res_drop_o;
    endproperty
    a_full: assert property (p_full) else $error("full queue kept packet"); // RULE11

    property p_addmax;
        @(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i |=> 15'(res_acct_len_o) <= 15'($past(pkt_len_i)) + 15'(QA_ADD_MAX);
    endproperty
    a_addmax: assert property (p_addmax) else $error("add above limit"); // RULE4

    property p_submin;
        @(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && pkt_len_i > 14'(QA_SUB_MAX)
            |=> res_acct_len_o >= $past(pkt_len_i) - 14'(QA_SUB_MAX);
    endproperty
    a_submin: assert property (p_submin) else $error("subtract above limit"); // RULE4

    property p_inprof;
        @(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && pkt_prof_i == QA_PROF_IN |=> res_hi_slope_o;
    endproperty
    a_inprof: assert property (p_inprof) else $error("in-profile not high"); // RULE9

    property p_outprof;
        @(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && pkt_prof_i == QA_PROF_OUT |=> !res_hi_slope_o;
    endproperty
    a_outprof: assert property (p_outprof) else $error("out-profile not low"); // RULE10

    property p_below;
        @(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && !full && util_x < 27'(sl_cur.start) * 27'(st.mbs) |=> !res_drop_o;
    endproperty
    a_below: assert property (p_below) else $error("drop below start"); // RULE12

    property p_knee;
        @(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && sl_cur.en && util_x >= 27'(sl_cur.maxu) * 27'(st.mbs) |=> res_drop_o;
    endproperty
    a_knee: assert property (p_knee) else $error("no drop above knee"); // RULE13

    property p_tx;
        @(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i |=> res_tx_len_o == $past(pkt_len_i);
    endproperty
    a_tx: assert property (p_tx) else $error("transmit length changed"); // RULE6

    // A shut down slope only discards through a full queue
    property p_slope_off;
        @(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && !full && !sl_cur.en |=> !res_drop_o;
    endproperty
    a_slope_off: assert property (p_slope_off) else $error("disabled slope dropped"); // RULE17

    // Main scenarios
    c_drop_full: cover property (@(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && full);
    c_random: cover property (@(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && !full && sl_cur.en && util_x >= 27'(sl_cur.start) * 27'(st.mbs)
        ##1 res_drop_o);
    c_sub: cover property (@(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && sub_eff && amt_eff != 6'h00);
    c_ovr: cover property (@(posedge clk_i) disable iff (!rst_sync_n)
        pkt_valid_i && st.ovr_en);
endmodule // qa_queue_acct
`default_nettype wire

// ==== bench/qa_sched_model.sv ====
// Scheduler side model: collects forwarded bytes and dequeues them on request.
// Assumes one clock, active low async reset, results one cycle after each packet.
`default_nettype none
module qa_sched_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        res_valid_i,
    input  wire logic        res_drop_i,
    input  wire logic [13:0] res_tx_len_i,
    input  wire logic        drain_i,
    output logic             deq_valid_o,
    output logic      [13:0] deq_len_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] backlog;

    // Backlog of forwarded bytes; idle length lines toggle so stale values never look valid
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            backlog     <= '0;
            deq_valid_o <= 1'b0;
            deq_len_o   <= '0;
        end else begin
            deq_valid_o <= 1'b0;
            deq_len_o   <= ~deq_len_o;
            if (drain_i && backlog != 14'h0) begin
                deq_valid_o <= 1'b1;
                deq_len_o   <= backlog;
                backlog     <= (res_valid_i && !res_drop_i) ? res_tx_len_i : 14'h0;
            end else if (res_valid_i && !res_drop_i) begin
                backlog <= backlog + res_tx_len_i;
            end
        end
    end
endmodule // qa_sched_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench for the queue accounting and discard block.
// Assumes register reads answer one cycle after the strobe and results follow packets by one cycle.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import qa_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        pkt_valid = 1'b0;
    logic [13:0] pkt_len = '0;
    logic        pkt_prio = 1'b0;
    logic [1:0]  pkt_prof = '0;
    logic        pkt_eg = 1'b0;
    logic        drain = 1'b0;
    logic        deq_valid, res_valid, res_drop, res_hi;
    logic [13:0] deq_len, res_acct, res_tx;
    logic [14:0] res_wire;
    logic [31:0] cnt_exp [6];
    int          miscompares = 0;
    int          total_checks = 0;
    int          eff = 0;
    int          i;
    logic [7:0]  adj_reg [6] = '{8'h00, 8'h14, 8'h1F, 8'h6B, 8'h7F, 8'h4E};
    int          adj_eff [6] = '{0, 20, 20, -43, -43, -14};
    logic [4:0]  map_tab [6] = '{5'h05, 5'h18, 5'h11, 5'h00, 5'h07, 5'h1A};

    // Clock of 50 ns period
    always #25 clk_i = ~clk_i;

    qa_queue_acct qa_queue_acct_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .pkt_valid_i(pkt_valid),
        .pkt_len_i(pkt_len), .pkt_prio_hi_i(pkt_prio), .pkt_prof_i(pkt_prof), .pkt_egress_i(pkt_eg),
        .deq_valid_i(deq_valid), .deq_len_i(deq_len), .res_valid_o(res_valid), .res_drop_o(res_drop),
        .res_hi_slope_o(res_hi), .res_acct_len_o(res_acct), .res_wire_len_o(res_wire),
        .res_tx_len_o(res_tx));

    qa_sched_model qa_sched_model_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .res_valid_i(res_valid), .res_drop_i(res_drop),
        .res_tx_len_i(res_tx), .drain_i(drain), .deq_valid_o(deq_valid), .deq_len_o(deq_len));

    // Comparison and report helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Register bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_i);
        reg_wr    <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_i);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp, "read");
        @(posedge clk_i);
    endtask

    // One packet with expected drop and slope; length and counters follow the active adjustment
    task automatic pkt(input logic prio, input logic [1:0] prof, input logic eg, input logic drop, input logic hi);
        logic [13:0] acct;
        int          c;
        acct = 14'(100 + eff);
        c = hi ? 0 : 1;
        pkt_len   <= 14'd100;
        pkt_prio  <= prio;
        pkt_prof  <= prof;
        pkt_eg    <= eg;
        pkt_valid <= 1'b1;
        @(posedge clk_i);
        pkt_valid <= 1'b0;
        #1;
        chk({31'h0, res_valid}, 32'h1, "valid");
        chk({31'h0, res_drop}, {31'h0, drop}, "drop");
        chk({31'h0, res_hi}, {31'h0, hi}, "slope");
        chk({18'h0, res_acct}, {18'h0, acct}, "acct");
        chk({17'h0, res_wire}, 32'd108, "wire");
        chk({18'h0, res_tx}, 32'd100, "tx");
        cnt_exp[c] += 32'(acct);
        if (drop) cnt_exp[c + 2] += 32'(acct);
        else cnt_exp[c + 4] += 32'(acct);
        @(posedge clk_i);
    endtask

    // Scheduler empties the queue
    task automatic drain_all;
        drain <= 1'b1;
        @(posedge clk_i);
        drain <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(QA_ADDR_DEPTH, 32'h0);
    endtask

    // Cut a hang short
    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        $display("BAD t=%0t run did not complete", $time);
        finish_test;
    end

    // Main sequence
    initial begin
        for (i = 0; i < 6; i++) cnt_exp[i] = '0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(QA_ADDR_ADJ, 32'h0);
        rd(QA_ADDR_MBS, 32'h0001_0000);
        rd(QA_ADDR_EXIST, 32'h1);
        rd(QA_ADDR_SLOPE, 32'h0101_5A5A);
        rd(QA_ADDR_SLOPE + 8'h01, 32'h0064_6464);
        rd(8'h07, 32'h0);
        // Each direction with its amount, clamped at the limits
        for (i = 0; i < 6; i++) begin
            wr(QA_ADDR_ADJ, {24'h0, adj_reg[i]});
            eff = adj_eff[i];
            pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b0, 1'b0);
        end
        wr(QA_ADDR_OVR, 32'h85);
        eff = 5;
        pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b0, 1'b0);
        wr(QA_ADDR_ADJ, 32'h0);
        pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b0, 1'b0);
        wr(QA_ADDR_OVR, 32'h0);
        eff = 0;
        pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b0, 1'b0);
        // Slope selection from priority and profile, in both directions
        for (i = 0; i < 6; i++) begin
            pkt(map_tab[i][4], map_tab[i][3:2], map_tab[i][1], 1'b0, map_tab[i][0]);
        end
        drain_all();
        // Default profile against a small queue
        wr(QA_ADDR_MBS, 32'd1000);
        for (i = 0; i < 9; i++) pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b0, 1'b0);
        pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b1, 1'b0);
        pkt(1'b1, QA_PROF_IN, 1'b0, 1'b0, 1'b1);
        pkt(1'b1, QA_PROF_IN, 1'b0, 1'b1, 1'b1);
        rd(QA_ADDR_DEPTH, 32'd1000);
        drain_all();
        // Profile edit applies at once
        wr(QA_ADDR_SLOPE, 32'h0101_3232);
        for (i = 0; i < 5; i++) pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b0, 1'b0);
        pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b1, 1'b0);
        // Assignment to absent and present profiles, then local override
        wr(QA_ADDR_ASSIGN, 32'h1);
        rd(QA_ADDR_ASSIGN, 32'h0);
        wr(QA_ADDR_EXIST, 32'h3);
        wr(QA_ADDR_ASSIGN, 32'h1);
        rd(QA_ADDR_ASSIGN, 32'h1);
        pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b0, 1'b0);
        wr(QA_ADDR_LOCAL, 32'h4);
        pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b1, 1'b0);
        // Local override on profile 1 must survive the revert to profile 0
        wr(QA_ADDR_LOCAL, 32'h5);
        wr(QA_ADDR_ASSIGN, 32'h0);
        pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b0, 1'b0);
        // Between start and knee: zero probability, then near-certain probability
        drain_all();
        wr(QA_ADDR_SLOPE, 32'h0100_0100);
        wr(QA_ADDR_MBS, 32'd10050);
        wr(QA_ADDR_LOCAL, 32'h0);
        for (i = 0; i < 2; i++) pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b0, 1'b0);
        drain_all();
        pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b0, 1'b0);
        wr(QA_ADDR_SLOPE, 32'h0164_0100);
        pkt(1'b0, QA_PROF_OUT, 1'b0, 1'b1, 1'b0);
        // Octet counters hold adjusted sizes
        for (i = 0; i < 6; i++) rd(QA_ADDR_CNT + 8'(i), cnt_exp[i]);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
